//--- icap_cfg.svh
// Register offsets, field positions, write masks, reset values and mode codes for the capture block
`ifndef ICAP_CFG_SVH
`define ICAP_CFG_SVH
`define ICAP_OFF_T2CTL    12'h000
`define ICAP_OFF_T2CNT    12'h004
`define ICAP_OFF_T3CTL    12'h008
`define ICAP_OFF_T3CNT    12'h00c
`define ICAP_OFF_CAPCTL   12'h010
`define ICAP_OFF_CAPBUF   12'h014
`define ICAP_OFF_IRQSTAT  12'h018
`define ICAP_OFF_IRQMASK  12'h01c
`define ICAP_OFF_IDLE     12'h020
`define ICAP_B_ON         15
`define ICAP_B_IDLE_STOP  13
`define ICAP_B_GATE       7
`define ICAP_B_PS_HI      6
`define ICAP_B_PS_LO      4
`define ICAP_B_PAIR       3
`define ICAP_B_CSRC       1
`define ICAP_B_FIRST_EDGE_SEL      9
`define ICAP_B_WIDE       8
`define ICAP_B_TSEL       7
`define ICAP_B_IRQ_HI     6
`define ICAP_B_IRQ_LO     5
`define ICAP_B_OVF        4
`define ICAP_B_BNE        3
`define ICAP_B_MODE_HI    2
`define ICAP_B_MODE_LO    0
`define ICAP_TCTL_WMASK   32'h0000a0fa
`define ICAP_TCTL_ODDMASK 32'h0000a0f2
`define ICAP_CCTL_WMASK   32'h0000a3e7
`define ICAP_RESET_WORD   32'h00000000
`define ICAP_MODE_OFF     3'h0
`define ICAP_MODE_EVERY   3'h1
`define ICAP_MODE_FALL    3'h2
`define ICAP_MODE_RISE    3'h3
`define ICAP_MODE_RISE4   3'h4
`define ICAP_MODE_RISE16  3'h5
`define ICAP_MODE_FIRST   3'h6
`define ICAP_IRQ_CAPTURE  0
`define ICAP_IRQ_OVF      1
`define ICAP_FIFO_DEPTH   4
`endif

//--- icap_pkg.sv
// Types shared by the capture block
package icap_pkg;
  typedef struct packed {
    logic       on;
    logic       idle_stop;
    logic       gate_accum_en;
    logic [2:0] prescale_sel;
    logic       pair_wide_mode;
    logic       clock_source_sel;
  } icap_tctl_s;
  typedef struct packed {
    logic       on;
    logic       idle_stop;
    logic       first_edge_sel;
    logic       wide_capture_sel;
    logic       capture_timer_sel;
    logic [1:0] capture_irq_every;
    logic [2:0] capture_mode_sel;
  } icap_cctl_s;
  typedef enum logic [1:0] {
    ICAP_ST_OFF   = 2'b00,
    ICAP_ST_FIRST = 2'b01,
    ICAP_ST_RUN   = 2'b10
  } icap_state_e;
endpackage

//--- icap_timer.sv
// One 16-bit timer with prescaler, gating, external source and idle stop
`timescale 1ns/1ps
`default_nettype none
`include "icap_cfg.svh"
module icap_timer
  import icap_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  var  icap_tctl_s       ctl,
  input  wire logic             idle,
  input  wire logic             ext_clk_rise,
  input  wire logic             gate_level,
  input  wire logic             cnt_wr,
  input  wire logic [WIDTH-1:0] cnt_wdata,
  output logic                  tick,
  output logic [WIDTH-1:0]      count
);
  logic [7:0] ps_q;
  logic [7:0] ps_lim;
  logic       src_tick;
  logic       run;

  always_comb begin
    case (ctl.prescale_sel)
      3'h0: ps_lim = 8'h00;
      3'h1: ps_lim = 8'h01;
      3'h2: ps_lim = 8'h03;
      3'h3: ps_lim = 8'h07;
      3'h4: ps_lim = 8'h0f;
      3'h5: ps_lim = 8'h1f;
      3'h6: ps_lim = 8'h3f;
      default: ps_lim = 8'hff;
    endcase
  end

  // Gate only honoured with internal source
  assign src_tick = ctl.clock_source_sel ? ext_clk_rise :
                    (ctl.gate_accum_en ? gate_level : 1'b1);
  assign run = ctl.on && !(ctl.idle_stop && idle);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps_q <= 8'h00;
    end else if (!run) begin
      ps_q <= 8'h00;
    end else if (src_tick) begin
      ps_q <= (ps_q >= ps_lim) ? 8'h00 : ps_q + 8'h01;
    end
  end

  assign tick = run && src_tick && (ps_q >= ps_lim);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (cnt_wr) begin
      count <= cnt_wdata;
    end else if (tick) begin
      count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule
`default_nettype wire

//--- icap_fifo.sv
// Small capture buffer with overflow discard
`timescale 1ns/1ps
`default_nettype none
`include "icap_cfg.svh"
module icap_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = `ICAP_FIFO_DEPTH
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             clr,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic             pop,
  output logic [WIDTH-1:0]      rdata,
  output logic                  nonempty,
  output logic                  full
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  logic             do_push;
  logic             do_pop;

  assign full     = (cnt_q == (AW+1)'(DEPTH));
  assign nonempty = (cnt_q != '0);
  assign do_push  = push && !full;
  assign do_pop   = pop && nonempty;
  assign rdata    = mem[rp_q];

  always_ff @(posedge pclk) begin
    if (do_push) begin
      mem[wp_q] <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else if (clr) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) begin
        wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + AW'(1);
      end
      if (do_pop) begin
        rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + AW'(1);
      end
      cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule
`default_nettype wire

//--- icap_top.sv
// Input capture unit with two pairable timers behind an APB slave
`timescale 1ns/1ps
`default_nettype none
`include "icap_cfg.svh"
// Contract
// - Timer idle-stop halts it in idle
// - External source ignores gate, reads zero
// - Prescale field divides 1 to 256
// - Pairing bit only on even timer
// - Wide pair controlled from even timer; the odd timer's own idle-stop still applies too
// - Capture disable resets and silences module
// - Capture idle-stop halts it in idle
// - Mode 110 first edge select
// - Width bit picks 32 or 16 bits
// - Timer select two/three in 16-bit
// - Interrupt every first to fourth capture
// - Read-only overflow flag
// - Read-only buffer nonempty bit
module icap_top
  import icap_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        cap_pin,
  input  wire logic        ext_clk_pin,
  input  wire logic        gate_pin,
  output logic             irq
);
  icap_tctl_s  t2_q;
  icap_tctl_s  t3_q;
  icap_cctl_s  c_q;
  icap_state_e st_q;
  logic [1:0]  irq_mask_q;
  logic [1:0]  irq_stat_q;
  logic        idle_q;
  logic        ovf_q;
  logic [1:0]  evt_q;
  logic [1:0]  div4_q;
  logic [3:0]  div16_q;
  logic [2:0]  cap_sync_q;
  logic [2:0]  ext_sync_q;
  logic [1:0]  gate_sync_q;
  logic        cap_rise;
  logic        cap_fall;
  logic        ext_rise;
  logic        cap_run;
  logic        edge_hit;
  logic        cap_evt;
  logic        irq_evt;
  logic        fifo_full;
  logic        fifo_ne;
  logic [31:0] fifo_rdata;
  logic [31:0] cap_value;
  logic        wr;
  logic        rd;
  logic        bad;
  logic [15:0] t2_cnt;
  logic [15:0] t3_cnt;
  logic        t2_tick;
  icap_tctl_s  t3_eff;
  icap_tctl_s  t3_view;

  function automatic logic is_addr(input logic [11:0] a, input logic [11:0] off);
    is_addr = (a == off);
  endfunction

  // Timer control readback hides gate when external source selected
  function automatic logic [31:0] tctl_word(input icap_tctl_s t, input logic even);
    logic [31:0] w;
    w = `ICAP_RESET_WORD;
    w[`ICAP_B_ON]        = t.on;
    w[`ICAP_B_IDLE_STOP] = t.idle_stop;
    w[`ICAP_B_GATE]      = t.gate_accum_en && !t.clock_source_sel;
    w[`ICAP_B_PS_HI:`ICAP_B_PS_LO] = t.prescale_sel;
    w[`ICAP_B_PAIR]      = even && t.pair_wide_mode;
    w[`ICAP_B_CSRC]      = t.clock_source_sel;
    tctl_word = w;
  endfunction

  assign wr  = psel && penable && pwrite;
  assign rd  = psel && penable && !pwrite;
  assign bad = !(is_addr(paddr, `ICAP_OFF_T2CTL) || is_addr(paddr, `ICAP_OFF_T2CNT) ||
                 is_addr(paddr, `ICAP_OFF_T3CTL) || is_addr(paddr, `ICAP_OFF_T3CNT) ||
                 is_addr(paddr, `ICAP_OFF_CAPCTL) || is_addr(paddr, `ICAP_OFF_CAPBUF) ||
                 is_addr(paddr, `ICAP_OFF_IRQSTAT) || is_addr(paddr, `ICAP_OFF_IRQMASK) ||
                 is_addr(paddr, `ICAP_OFF_IDLE));
  assign pready  = 1'b1;
  assign pslverr = psel && penable && bad;

  // Pin synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_sync_q  <= 3'h0;
      ext_sync_q  <= 3'h0;
      gate_sync_q <= 2'h0;
    end else begin
      cap_sync_q  <= {cap_sync_q[1:0], cap_pin};
      ext_sync_q  <= {ext_sync_q[1:0], ext_clk_pin};
      gate_sync_q <= {gate_sync_q[0], gate_pin};
    end
  end
  assign cap_rise = cap_sync_q[1] && !cap_sync_q[2];
  assign cap_fall = !cap_sync_q[1] && cap_sync_q[2];
  assign ext_rise = ext_sync_q[1] && !ext_sync_q[2];

  // In pair mode the odd timer takes its enable from the even one and its tick from the even rollover
  always_comb begin
    t3_eff = t3_q;
    if (t2_q.pair_wide_mode) begin
      t3_eff.on               = t2_q.on;
      // Gate input carries the even rollover, so the odd half counts carries only
      t3_eff.gate_accum_en    = 1'b1;
      t3_eff.prescale_sel     = 3'h0;
      t3_eff.clock_source_sel = 1'b0;
      // Odd idle-stop still applies; software must clear it
      t3_eff.idle_stop        = t2_q.idle_stop || t3_q.idle_stop;
    end
  end
  assign t3_view = t3_q;

  icap_timer #(.WIDTH(16)) u_t2 (
    .pclk         (pclk),
    .presetn      (presetn),
    .ctl          (t2_q),
    .idle         (idle_q),
    .ext_clk_rise (ext_rise),
    .gate_level   (gate_sync_q[1]),
    .cnt_wr       (wr && is_addr(paddr, `ICAP_OFF_T2CNT)),
    .cnt_wdata    (pwdata[15:0]),
    .tick         (t2_tick),
    .count        (t2_cnt)
  );

  icap_timer #(.WIDTH(16)) u_t3 (
    .pclk         (pclk),
    .presetn      (presetn),
    .ctl          (t3_eff),
    .idle         (idle_q),
    .ext_clk_rise (ext_rise),
    .gate_level   (t2_q.pair_wide_mode ? (t2_tick && t2_cnt == 16'hffff) : gate_sync_q[1]),
    .cnt_wr       (wr && is_addr(paddr, `ICAP_OFF_T3CNT)),
    .cnt_wdata    (pwdata[15:0]),
    .tick         (),
    .count        (t3_cnt)
  );

  // Pair carry: odd timer gated by even rollover through gate input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t2_q <= '0;
      t3_q <= '0;
    end else if (wr && is_addr(paddr, `ICAP_OFF_T2CTL)) begin
      t2_q <= {pwdata[`ICAP_B_ON], pwdata[`ICAP_B_IDLE_STOP], pwdata[`ICAP_B_GATE],
               pwdata[`ICAP_B_PS_HI:`ICAP_B_PS_LO], pwdata[`ICAP_B_PAIR],
               pwdata[`ICAP_B_CSRC]};
    end else if (wr && is_addr(paddr, `ICAP_OFF_T3CTL)) begin
      // Odd timer has no pairing bit
      t3_q <= {pwdata[`ICAP_B_ON], pwdata[`ICAP_B_IDLE_STOP], pwdata[`ICAP_B_GATE],
               pwdata[`ICAP_B_PS_HI:`ICAP_B_PS_LO], 1'b0, pwdata[`ICAP_B_CSRC]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_q <= 1'b0;
    end else if (wr && is_addr(paddr, `ICAP_OFF_IDLE)) begin
      idle_q <= pwdata[0];
    end
  end

  // Fields other than enable and idle-stop change only while disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c_q <= '0;
    end else if (wr && is_addr(paddr, `ICAP_OFF_CAPCTL)) begin
      c_q.on        <= pwdata[`ICAP_B_ON];
      c_q.idle_stop <= pwdata[`ICAP_B_IDLE_STOP];
      if (!c_q.on) begin
        c_q.first_edge_sel    <= pwdata[`ICAP_B_FIRST_EDGE_SEL];
        c_q.wide_capture_sel  <= pwdata[`ICAP_B_WIDE];
        c_q.capture_timer_sel <= pwdata[`ICAP_B_TSEL];
        c_q.capture_irq_every <= pwdata[`ICAP_B_IRQ_HI:`ICAP_B_IRQ_LO];
        c_q.capture_mode_sel  <= pwdata[`ICAP_B_MODE_HI:`ICAP_B_MODE_LO];
      end
    end
  end

  assign cap_run = c_q.on && !(c_q.idle_stop && idle_q);

  // Edge qualifier per mode
  always_comb begin
    case (c_q.capture_mode_sel)
      `ICAP_MODE_EVERY:  edge_hit = cap_rise || cap_fall;
      `ICAP_MODE_FALL:   edge_hit = cap_fall;
      `ICAP_MODE_RISE:   edge_hit = cap_rise;
      `ICAP_MODE_RISE4:  edge_hit = cap_rise && (div4_q == 2'h3);
      `ICAP_MODE_RISE16: edge_hit = cap_rise && (div16_q == 4'hf);
      `ICAP_MODE_FIRST:  edge_hit = (st_q == ICAP_ST_FIRST) ?
                           (c_q.first_edge_sel ? cap_rise : cap_fall) :
                           (cap_rise || cap_fall);
      default:           edge_hit = 1'b0;
    endcase
  end
  assign cap_evt = cap_run && (st_q != ICAP_ST_OFF) && edge_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ICAP_ST_OFF;
    end else begin
      case (st_q)
        ICAP_ST_OFF:   st_q <= (c_q.on && c_q.capture_mode_sel != `ICAP_MODE_OFF) ?
                               ICAP_ST_FIRST : ICAP_ST_OFF;
        ICAP_ST_FIRST: st_q <= !c_q.on ? ICAP_ST_OFF : (cap_evt ? ICAP_ST_RUN : ICAP_ST_FIRST);
        ICAP_ST_RUN:   st_q <= !c_q.on ? ICAP_ST_OFF : ICAP_ST_RUN;
        default:       st_q <= ICAP_ST_OFF;
      endcase
    end
  end

  // Prescale counters for the every-fourth and every-sixteenth modes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div4_q  <= 2'h0;
      div16_q <= 4'h0;
    end else if (!c_q.on) begin
      div4_q  <= 2'h0;
      div16_q <= 4'h0;
    end else if (cap_run && cap_rise) begin
      div4_q  <= div4_q + 2'h1;
      div16_q <= div16_q + 4'h1;
    end
  end

  always_comb begin
    if (c_q.wide_capture_sel) begin
      cap_value = {t3_cnt, t2_cnt};
    end else begin
      cap_value = {16'h0000, c_q.capture_timer_sel ? t2_cnt : t3_cnt};
    end
  end

  icap_fifo #(.WIDTH(32), .DEPTH(`ICAP_FIFO_DEPTH)) u_fifo (
    .pclk     (pclk),
    .presetn  (presetn),
    .clr      (!c_q.on),
    .push     (cap_evt),
    .wdata    (cap_value),
    .pop      (rd && is_addr(paddr, `ICAP_OFF_CAPBUF)),
    .rdata    (fifo_rdata),
    .nonempty (fifo_ne),
    .full     (fifo_full)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_q <= 1'b0;
    end else if (!c_q.on) begin
      ovf_q <= 1'b0;
    end else if (cap_evt && fifo_full) begin
      ovf_q <= 1'b1;
    end
  end

  // Interrupt divider; reset together with the module
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_q <= 2'h0;
    end else if (!c_q.on) begin
      evt_q <= 2'h0;
    end else if (cap_evt) begin
      evt_q <= (evt_q == c_q.capture_irq_every) ? 2'h0 : evt_q + 2'h1;
    end
  end
  assign irq_evt = cap_evt && (evt_q == c_q.capture_irq_every) && c_q.on;

  // Sticky status; a new event beats the read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= 2'h0;
    end else begin
      irq_stat_q[`ICAP_IRQ_CAPTURE] <= irq_evt ||
        (irq_stat_q[`ICAP_IRQ_CAPTURE] && !(rd && is_addr(paddr, `ICAP_OFF_IRQSTAT)));
      irq_stat_q[`ICAP_IRQ_OVF] <= (c_q.on && cap_evt && fifo_full) ||
        (irq_stat_q[`ICAP_IRQ_OVF] && !(rd && is_addr(paddr, `ICAP_OFF_IRQSTAT)));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= 2'h0;
    end else if (wr && is_addr(paddr, `ICAP_OFF_IRQMASK)) begin
      irq_mask_q <= pwdata[1:0];
    end
  end
  assign irq = |(irq_stat_q & irq_mask_q);

  always_comb begin
    prdata = `ICAP_RESET_WORD;
    if (rd) begin
      case (paddr)
        `ICAP_OFF_T2CTL:   prdata = tctl_word(t2_q, 1'b1);
        `ICAP_OFF_T2CNT:   prdata = {16'h0000, t2_cnt};
        `ICAP_OFF_T3CTL:   prdata = tctl_word(t3_view, 1'b0);
        `ICAP_OFF_T3CNT:   prdata = {16'h0000, t3_cnt};
        `ICAP_OFF_CAPCTL: begin
          prdata[`ICAP_B_ON]        = c_q.on;
          prdata[`ICAP_B_IDLE_STOP] = c_q.idle_stop;
          prdata[`ICAP_B_FIRST_EDGE_SEL]     = c_q.first_edge_sel;
          prdata[`ICAP_B_WIDE]      = c_q.wide_capture_sel;
          prdata[`ICAP_B_TSEL]      = c_q.capture_timer_sel;
          prdata[`ICAP_B_IRQ_HI:`ICAP_B_IRQ_LO] = c_q.capture_irq_every;
          prdata[`ICAP_B_OVF]       = ovf_q;
          prdata[`ICAP_B_BNE]       = fifo_ne;
          prdata[`ICAP_B_MODE_HI:`ICAP_B_MODE_LO] = c_q.capture_mode_sel;
        end
        `ICAP_OFF_CAPBUF:  prdata = fifo_rdata;
        `ICAP_OFF_IRQSTAT: prdata = {30'h00000000, irq_stat_q};
        `ICAP_OFF_IRQMASK: prdata = {30'h00000000, irq_mask_q};
        `ICAP_OFF_IDLE:    prdata = {31'h00000000, idle_q};
        default:           prdata = `ICAP_RESET_WORD;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- icap_top_sva.sv
// Port-level assertions for the capture block
`timescale 1ns/1ps
`default_nettype none
`include "icap_cfg.svh"
module icap_top_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        cap_pin,
  input wire logic        ext_clk_pin,
  input wire logic        gate_pin,
  input wire logic        irq
);
  logic [31:0] t2_q, t3_q, cc_q;
  logic [1:0]  msk_q;
  // Shadow of the control words; capture fields lock while it is on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t2_q <= '0;
      t3_q <= '0;
      cc_q <= '0;
      msk_q <= '0;
    end else if (psel && penable && pready && pwrite) begin
      case (paddr)
        `ICAP_OFF_T2CTL: t2_q <= pwdata & `ICAP_TCTL_WMASK;
        `ICAP_OFF_T3CTL: t3_q <= pwdata & `ICAP_TCTL_ODDMASK;
        `ICAP_OFF_CAPCTL: cc_q <= cc_q[15] ?
          {cc_q[31:16], pwdata[15], 1'b0, pwdata[13], cc_q[12:0]} :
          pwdata & `ICAP_CCTL_WMASK;
        `ICAP_OFF_IRQMASK: msk_q <= pwdata[1:0];
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_rd(logic [11:0] a);
    psel && penable && !pwrite && paddr == a;
  endsequence
  a_ready_high:
    assert property (psel && penable |-> pready) else $error("pready low in access");
  a_unmapped_err:
    assert property (psel && penable && paddr > `ICAP_OFF_IDLE |-> pslverr && prdata == '0)
    else $error("unmapped access not refused");
  a_even_ctl:
    assert property (s_rd(`ICAP_OFF_T2CTL) |->
      prdata == {t2_q[31:8], t2_q[7] & !t2_q[1], t2_q[6:0]}) else $error("timer two ctl");
  a_odd_ctl:
    assert property (s_rd(`ICAP_OFF_T3CTL) |->
      prdata == {t3_q[31:8], t3_q[7] & !t3_q[1], t3_q[6:0]}) else $error("timer three ctl");
  a_cap_ctl:
    assert property (s_rd(`ICAP_OFF_CAPCTL) |-> (prdata & 32'hffffffe7) == cc_q)
    else $error("capture ctl readback");
  a_off_flags:
    assert property (s_rd(`ICAP_OFF_CAPCTL) ##0 !cc_q[15] |-> prdata[4:3] == 2'b00)
    else $error("flags set while off");
  a_irq_masked:
    assert property (msk_q == 2'b00 && $past(msk_q) == 2'b00 |-> !irq)
    else $error("irq with mask clear");
  a_reset_quiet:
    assert property ($rose(presetn) |-> !irq [*2]) else $error("irq after reset");
endmodule
bind icap_top icap_top_sva u_icap_top_sva (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .prdata, .pslverr, .cap_pin, .ext_clk_pin, .gate_pin, .irq
);
`default_nettype wire

//--- icap_pin_src.sv
// Far-side pin model: capture input, external timer clock and gate level
`timescale 1ns/1ps
`default_nettype none
module icap_pin_src (
  input  wire logic pclk,
  output var  logic cap_pin,
  output var  logic ext_clk_pin,
  output var  logic gate_pin
);
  initial begin
    cap_pin = 1'b0;
    ext_clk_pin = 1'b0;
    gate_pin = 1'b0;
  end
  // Hold is cycles per level; long holds model a slow source
  task automatic pulse(input int which, input int n, input int hold);
    repeat (n) begin
      drive(which, 1'b1, hold);
      drive(which, 1'b0, hold);
    end
  endtask
  task automatic drive(input int which, input logic v, input int hold);
    @(posedge pclk);
    if (which == 0) cap_pin <= v;
    else ext_clk_pin <= v;
    repeat (hold - 1) @(posedge pclk);
  endtask
  task automatic set_gate(input logic v);
    @(posedge pclk);
    gate_pin <= v;
  endtask
endmodule
`default_nettype wire

//--- test_input_capture_with_timer_base.sv
// Self-checking bench for the capture block over its APB port
`timescale 1ns/1ps
`default_nettype none
`include "icap_cfg.svh"
module test_input_capture_with_timer_base;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, serr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  wire         cap_pin, ext_clk_pin, gate_pin;
  int          err_count, check_count, n, dv;
  logic [31:0] wcfg [3] = '{32'h0003, 32'h0083, 32'h0183};
  logic [31:0] wexp [3] = '{32'h0005, 32'h5678, 32'h00055678};
  // Mode rows: control word, pulses, entries expected
  logic [31:0] mcfg [10] = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h4, 32'h5, 32'h206,
                             32'h6, 32'h7, 32'h2003};
  int          mpul [10] = '{2, 2, 2, 2, 4, 4, 2, 2, 2, 2};
  int          mexp [10] = '{0, 4, 2, 2, 1, 0, 4, 3, 0, 0};
  icap_top u_icap_top (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .cap_pin, .ext_clk_pin, .gate_pin, .irq
  );
  icap_pin_src u_icap_pin_src (.pclk, .cap_pin, .ext_clk_pin, .gate_pin);
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // Idle cycle after every transfer keeps the cycle after a disable free
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No wait-state count assumed; only the watchdog ends a stuck wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rv = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    chk(rv, e);
  endtask
  task automatic chk_irq(input logic e);
    @(negedge pclk);
    chk({31'h0, irq}, {31'h0, e});
    @(posedge pclk);
  endtask
  // Flush by switching off, set fields while off, then switch on
  task automatic cap_on(input logic [31:0] c);
    wr(`ICAP_OFF_CAPCTL, 32'h0);
    wr(`ICAP_OFF_CAPCTL, c);
    wr(`ICAP_OFF_CAPCTL, c | 32'h8000);
  endtask
  task automatic drain();
    n = 0;
    rd(`ICAP_OFF_CAPCTL);
    while (rv[`ICAP_B_BNE] === 1'b1 && n < 6) begin
      rd(`ICAP_OFF_CAPBUF);
      n++;
      rd(`ICAP_OFF_CAPCTL);
    end
  endtask
  task automatic conclude();
    if (err_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge pclk);
    err_count++;
    conclude();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    err_count = 0;
    check_count = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 0; a <= 32; a += 4) rdchk(12'(a), 32'h0);
    rd(12'h024);
    chk({31'h0, serr}, 32'h1);
    wr(`ICAP_OFF_T2CTL, 32'hffffffff);
    rdchk(`ICAP_OFF_T2CTL, 32'h0000a07a);
    wr(`ICAP_OFF_T3CTL, 32'hffffffff);
    rdchk(`ICAP_OFF_T3CTL, 32'h0000a072);
    wr(`ICAP_OFF_T3CTL, 32'h0);
    for (int p = 0; p < 8; p++) begin
      dv = (p == 7) ? 256 : (1 << p);
      wr(`ICAP_OFF_T2CNT, 32'h0);
      wr(`ICAP_OFF_T2CTL, 32'h8000 | (32'(p) << 4));
      repeat (8 * dv - 3) @(posedge pclk);
      wr(`ICAP_OFF_T2CTL, 32'h0);
      rd(`ICAP_OFF_T2CNT);
      chk(32'(rv >= 7 && rv <= 9), 32'h1);
    end
    wr(`ICAP_OFF_T2CNT, 32'h0);
    wr(`ICAP_OFF_T2CTL, 32'h8080);
    repeat (16) @(posedge pclk);
    rdchk(`ICAP_OFF_T2CNT, 32'h0);
    u_icap_pin_src.set_gate(1'b1);
    repeat (15) @(posedge pclk);
    u_icap_pin_src.set_gate(1'b0);
    rd(`ICAP_OFF_T2CNT);
    chk(32'(rv >= 14 && rv <= 18), 32'h1);
    wr(`ICAP_OFF_T2CNT, 32'h0);
    wr(`ICAP_OFF_T2CTL, 32'h8082);
    u_icap_pin_src.pulse(1, 5, 2);
    repeat (4) @(posedge pclk);
    rdchk(`ICAP_OFF_T2CNT, 32'h5);
    wr(`ICAP_OFF_IDLE, 32'h1);
    wr(`ICAP_OFF_T2CNT, 32'h0);
    wr(`ICAP_OFF_T2CTL, 32'ha000);
    repeat (20) @(posedge pclk);
    rdchk(`ICAP_OFF_T2CNT, 32'h0);
    wr(`ICAP_OFF_T2CTL, 32'h8000);
    repeat (20) @(posedge pclk);
    wr(`ICAP_OFF_T2CTL, 32'h0);
    rd(`ICAP_OFF_T2CNT);
    chk(32'(rv >= 22 && rv <= 24), 32'h1);
    wr(`ICAP_OFF_IDLE, 32'h0);
    wr(`ICAP_OFF_T2CNT, 32'hfffe);
    wr(`ICAP_OFF_T3CNT, 32'h0);
    wr(`ICAP_OFF_T3CTL, 32'h0070); // Odd idle stop left clear
    wr(`ICAP_OFF_T2CTL, 32'h8008);
    repeat (5) @(posedge pclk);
    wr(`ICAP_OFF_T2CTL, 32'h0);
    rdchk(`ICAP_OFF_T3CNT, 32'h1);
    wr(`ICAP_OFF_T3CTL, 32'h0);
    wr(`ICAP_OFF_T2CNT, 32'h5678);
    wr(`ICAP_OFF_IRQMASK, 32'h3);
    cap_on(32'h0003);
    for (int i = 1; i <= 5; i++) begin
      wr(`ICAP_OFF_T3CNT, 32'(i));
      u_icap_pin_src.pulse(0, 1, 4);
    end
    rdchk(`ICAP_OFF_CAPCTL, 32'h801b);
    wr(`ICAP_OFF_CAPCTL, 32'h8002);
    rdchk(`ICAP_OFF_CAPCTL, 32'h801b);
    chk_irq(1'b1);
    rdchk(`ICAP_OFF_IRQSTAT, 32'h3);
    rdchk(`ICAP_OFF_IRQSTAT, 32'h0);
    chk_irq(1'b0);
    for (int i = 1; i <= 4; i++) rdchk(`ICAP_OFF_CAPBUF, 32'(i));
    rdchk(`ICAP_OFF_CAPCTL, 32'h8013);
    wr(`ICAP_OFF_CAPCTL, 32'h0);
    rdchk(`ICAP_OFF_CAPCTL, 32'h0003);
    for (int k = 0; k < 3; k++) begin
      cap_on(wcfg[k]);
      u_icap_pin_src.pulse(0, 1, 4);
      rdchk(`ICAP_OFF_CAPBUF, wexp[k]);
    end
    wr(`ICAP_OFF_IDLE, 32'h1);
    for (int r = 0; r < 10; r++) begin
      cap_on(mcfg[r]);
      u_icap_pin_src.pulse(0, mpul[r], (r % 2) ? 9 : 3);
      drain();
      chk(32'(n), 32'(mexp[r]));
    end
    wr(`ICAP_OFF_IDLE, 32'h0);
    wr(`ICAP_OFF_IRQMASK, 32'h1);
    for (int e = 0; e < 4; e++) begin
      cap_on(32'h0003 | (32'(e) << 5));
      rd(`ICAP_OFF_IRQSTAT);
      u_icap_pin_src.pulse(0, e, 3);
      chk_irq(1'b0);
      u_icap_pin_src.pulse(0, 1, 3);
      chk_irq(1'b1);
    end
    wr(`ICAP_OFF_IRQMASK, 32'h0);
    chk_irq(1'b0);
    wr(`ICAP_OFF_IRQMASK, 32'h1);
    chk_irq(1'b1);
    rd(`ICAP_OFF_IRQSTAT);
    chk_irq(1'b0);
    conclude();
  end
endmodule
`default_nettype wire
